/* File: pkg/bth_pkg.sv */
// Purpose: constants and carriers for the bridge header identity and BAR words
// Assumes: 32-bit configuration access port with byte enables
// Notes: offsets are byte addresses within the configuration header
package bth_pkg;
  localparam logic [7:0] BTH_OFS_CLASS_REV = 8'h08;
  localparam logic [7:0] BTH_OFS_MISC = 8'h0C;
  localparam logic [7:0] BTH_OFS_BASE_LOW = 8'h10;
  localparam logic [7:0] BTH_OFS_BASE_HIGH = 8'h14;
  localparam logic [7:0] BTH_PROG_IF = 8'h00;
  localparam logic [7:0] BTH_SUB_CLASS = 8'h04;
  localparam logic [7:0] BTH_BASE_CLASS = 8'h06;
  localparam logic [7:0] BTH_CLS_RESET = 8'h00;
  localparam logic [7:0] BTH_LAT_RESET_PCI = 8'h00;
  localparam logic [7:0] BTH_LAT_RESET_PCIX = 8'h40;
  localparam logic [6:0] BTH_HDR_TYPE = 7'h01;
  localparam logic [1:0] BTH_MAP_32 = 2'h0;
  localparam logic [1:0] BTH_MAP_64 = 2'h2;
  localparam int BTH_BASE_LSB = 13;
  localparam logic [18:0] BTH_BASE_LOW_RESET = 19'h00000;
  localparam logic [31:0] BTH_BASE_HIGH_RESET = 32'h00000000;
  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bth_cfg_req_t;
  // Serial EEPROM preload strobe
  typedef struct packed {
    logic ld_rev;
    logic [7:0] rev;
    logic ld_cls;
    logic [7:0] cls;
    logic ld_lat;
    logic [7:0] lat;
    logic ld_map;
    logic [1:0] map;
    logic ld_base_low;
    logic [18:0] base_low;
    logic ld_base_high;
    logic [31:0] base_high;
  } bth_eep_t;
endpackage

/* File: core/bth_header_regs.sv */
// Purpose: identity, cache line, latency, header type and BAR words of the bridge
// Assumes: single clock, configuration requests one cycle wide, EEPROM strobes likewise
// Notes: read data registered one cycle after the read request
`timescale 1ns/1ps
module bth_header_regs
  import bth_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'hA5 // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reverse_mode,
  input wire logic pcix_mode,
  input wire logic bus_64,
  input wire bth_cfg_req_t cfg_req,
  input wire bth_eep_t eep,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [5:0] cache_line_dw,
  output logic [7:0] prim_latency,
  output logic [63:0] window_base
);

  // Byte lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [7:0] rev_q, rev_d;
  logic [7:0] cls_q, cls_d;
  logic [7:0] lat_q, lat_d;
  logic [1:0] map_q, map_d;
  logic [18:0] blo_q, blo_d;
  logic [31:0] bhi_q, bhi_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic lat_init_q, lat_init_d;
  logic [31:0] class_word, misc_word, blo_word, bhi_word, m;
  logic is64;

  assign is64 = (map_q == BTH_MAP_64);

  // Read images of the four words
  always_comb begin
    class_word = {BTH_BASE_CLASS, BTH_SUB_CLASS, BTH_PROG_IF, rev_q};
    misc_word = {8'h00, 1'b0, BTH_HDR_TYPE,
                 (reverse_mode ? lat_q : 8'h00), cls_q};
    blo_word = {blo_q, 9'h000, 1'b0, map_q, 1'b0};
    bhi_word = is64 ? bhi_q : 32'h00000000;
  end

  // Next state of the writable fields
  always_comb begin
    rev_d = rev_q;
    cls_d = cls_q;
    lat_d = lat_q;
    map_d = map_q;
    blo_d = blo_q;
    bhi_d = bhi_q;
    lat_init_d = 1'b1;
    m = 32'h00000000;
    // Latency reset value follows bus flavour, caught after reset release
    if (!lat_init_q) begin
      lat_d = pcix_mode ? BTH_LAT_RESET_PCIX : BTH_LAT_RESET_PCI;
    end
    if (cfg_req.wr) begin
      case (cfg_req.addr)
        BTH_OFS_MISC: begin
          m = merge(misc_word, cfg_req.wdata, cfg_req.be);
          cls_d = m[7:0];
          if (reverse_mode) begin
            lat_d = m[15:8];
          end
        end
        BTH_OFS_BASE_LOW: begin
          m = merge(blo_word, cfg_req.wdata, cfg_req.be);
          blo_d = m[31:BTH_BASE_LSB];
        end
        BTH_OFS_BASE_HIGH: begin
          if (is64) begin
            bhi_d = merge(bhi_q, cfg_req.wdata, cfg_req.be);
          end
        end
        default: begin
          m = 32'h00000000;
        end
      endcase
    end
    // EEPROM preload has priority over software
    if (eep.ld_rev) rev_d = eep.rev;
    if (eep.ld_cls) cls_d = eep.cls;
    if (eep.ld_lat) lat_d = eep.lat;
    if (eep.ld_map) map_d = eep.map;
    if (eep.ld_base_low) blo_d = eep.base_low;
    if (eep.ld_base_high) bhi_d = eep.base_high;
  end

  // Registered read path
  always_comb begin
    rvalid_d = cfg_req.rd;
    rdata_d = 32'h00000000;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        BTH_OFS_CLASS_REV: rdata_d = class_word;
        BTH_OFS_MISC: rdata_d = misc_word;
        BTH_OFS_BASE_LOW: rdata_d = blo_word;
        BTH_OFS_BASE_HIGH: rdata_d = bhi_word;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rev_q <= SILICON_REV;
      cls_q <= BTH_CLS_RESET;
      lat_q <= BTH_LAT_RESET_PCI;
      map_q <= BTH_MAP_32;
      blo_q <= BTH_BASE_LOW_RESET;
      bhi_q <= BTH_BASE_HIGH_RESET;
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
      lat_init_q <= 1'b0;
    end else begin
      rev_q <= rev_d;
      cls_q <= cls_d;
      lat_q <= lat_d;
      map_q <= map_d;
      blo_q <= blo_d;
      bhi_q <= bhi_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      lat_init_q <= lat_init_d;
    end
  end

  // Effective values for the datapath
  always_comb begin
    cache_line_dw = cls_q[5:0];
    if (cls_q == 8'h00) begin
      cache_line_dw = bus_64 ? 6'h02 : 6'h01;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign prim_latency = reverse_mode ? lat_q : 8'h00;
  assign window_base = {bhi_word, blo_q, 13'h0000};

  // Assertions
  class_ro_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == BTH_OFS_CLASS_REV |=> cfg_rdata[31:8] == 24'h060400)
    else $error("class code wrong");
  prog_if_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_rvalid && $past(cfg_req.addr) == BTH_OFS_CLASS_REV |-> cfg_rdata[15:8] == 8'h00)
    else $error("programming interface not zero");
  rev_load_a: assert property (@(posedge clk) disable iff (!nrst)
    eep.ld_rev ##1 (cfg_req.rd && cfg_req.addr == BTH_OFS_CLASS_REV && !eep.ld_rev)
    |=> cfg_rdata[7:0] == $past(eep.rev, 2))
    else $error("revision preload lost");
  hdr_type_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == BTH_OFS_MISC |=> cfg_rdata[31:16] == 16'h0001)
    else $error("header type word wrong");
  fwd_lat_a: assert property (@(posedge clk) disable iff (!nrst)
    !reverse_mode |-> prim_latency == 8'h00)
    else $error("latency not zero in forward mode");
  cls_write_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == BTH_OFS_MISC && cfg_req.be[0] && !eep.ld_cls
    ##1 (cfg_req.rd && cfg_req.addr == BTH_OFS_MISC && !cfg_req.wr)
    |=> cfg_rdata[7:0] == $past(cfg_req.wdata[7:0], 2))
    else $error("cache line write lost");
  cls_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    cls_q == 8'h00 |-> cache_line_dw == (bus_64 ? 6'h02 : 6'h01))
    else $error("zero cache line size mishandled");
  lat_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(lat_init_q) && !$past(eep.ld_lat) && !$past(cfg_req.wr)
    |-> lat_q == (pcix_mode ? 8'h40 : 8'h00))
    else $error("latency reset value wrong");
  bar_low_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr == BTH_OFS_BASE_LOW
    |=> cfg_rdata[12:3] == 10'h000 && cfg_rdata[0] == 1'b0)
    else $error("BAR low fixed bits not zero");
  map_ro_a: assert property (@(posedge clk) disable iff (!nrst)
    !eep.ld_map |=> map_q == $past(map_q))
    else $error("map type changed without preload");
  bar_high_a: assert property (@(posedge clk) disable iff (!nrst)
    !is64 && cfg_req.rd && cfg_req.addr == BTH_OFS_BASE_HIGH |=> cfg_rdata == 32'h0)
    else $error("BAR high not zero in 32-bit mode");
  bar_high_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    is64 && cfg_req.wr && cfg_req.addr == BTH_OFS_BASE_HIGH && cfg_req.be == 4'hF
    && !eep.ld_base_high |=> bhi_q == $past(cfg_req.wdata))
    else $error("BAR high write lost");

  // Preload strobe followed by a quiet cycle
  sequence rev_load_s;
    eep.ld_rev ##1 !eep.ld_rev;
  endsequence

  // Software write of the cache line byte, no competing preload
  sequence cls_write_s;
    cfg_req.wr && cfg_req.addr == BTH_OFS_MISC && cfg_req.be[0] && !eep.ld_cls;
  endsequence

  // Full-word software write of the low BAR, no competing preload
  sequence base_low_write_s;
    cfg_req.wr && cfg_req.addr == BTH_OFS_BASE_LOW && cfg_req.be == 4'hF && !eep.ld_base_low;
  endsequence

  // Preloaded revision is in place in the cycle after the strobe
  rev_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    rev_load_s |-> rev_q == $past(eep.rev))
    else $error("revision preload not held");

  // Cache line byte takes the written value
  cls_store_a: assert property (@(posedge clk) disable iff (!nrst)
    cls_write_s |=> cls_q == $past(cfg_req.wdata[7:0]))
    else $error("cache line byte not stored");

  // Low BAR base takes the written upper bits
  blo_store_a: assert property (@(posedge clk) disable iff (!nrst)
    base_low_write_s |=> blo_q == $past(cfg_req.wdata[31:13]))
    else $error("low BAR base not stored");

  // Every read is answered in the next cycle
  rvalid_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered");

  // No read, no answer and a quiet data bus
  rvalid_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 32'h00000000)
    else $error("answer without a read");

  // Writes to the class word leave the revision alone
  class_wr_ign_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.wr && cfg_req.addr == BTH_OFS_CLASS_REV && !eep.ld_rev |=> rev_q == $past(rev_q))
    else $error("class word write not ignored");

  // Multi-function bit and self-test byte read zero
  multi_fn_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_rvalid && $past(cfg_req.addr) == BTH_OFS_MISC |-> cfg_rdata[31:23] == 9'h000)
    else $error("function or self-test bits not zero");

  // Low BAR read shows the map type in effect
  map_image_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_rvalid && $past(cfg_req.addr) == BTH_OFS_BASE_LOW |-> cfg_rdata[2:1] == $past(map_q))
    else $error("map type image wrong");

  // High BAR frozen against software while the map type is 32-bit
  bhi_ro_a: assert property (@(posedge clk) disable iff (!nrst)
    !is64 && !eep.ld_base_high |=> bhi_q == $past(bhi_q))
    else $error("high BAR changed in 32-bit mode");

  // Forward mode latency ignores software
  lat_fwd_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    !reverse_mode && lat_init_q && !eep.ld_lat |=> lat_q == $past(lat_q))
    else $error("latency changed in forward mode");

  // Reverse mode latency takes the written byte
  lat_rev_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    reverse_mode && lat_init_q && cfg_req.wr && cfg_req.addr == BTH_OFS_MISC
    && cfg_req.be[1] && !eep.ld_lat |=> lat_q == $past(cfg_req.wdata[15:8]))
    else $error("latency write lost in reverse mode");

  // Cache line preload lands
  cls_load_a: assert property (@(posedge clk) disable iff (!nrst)
    eep.ld_cls |=> cls_q == $past(eep.cls))
    else $error("cache line preload lost");

  // Map type preload lands
  map_load_a: assert property (@(posedge clk) disable iff (!nrst)
    eep.ld_map |=> map_q == $past(eep.map))
    else $error("map type preload lost");

  // Non-zero cache line passes straight through
  cls_plain_a: assert property (@(posedge clk) disable iff (!nrst)
    cls_q != 8'h00 |-> cache_line_dw == cls_q[5:0])
    else $error("cache line value altered");

  // Window upper half zero unless 64-bit map
  win_high_a: assert property (@(posedge clk) disable iff (!nrst)
    !is64 |-> window_base[63:32] == 32'h00000000)
    else $error("window upper half not zero");

  // Unmapped offsets read zero
  unmapped_rd_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg_req.rd && cfg_req.addr != BTH_OFS_CLASS_REV && cfg_req.addr != BTH_OFS_MISC
    && cfg_req.addr != BTH_OFS_BASE_LOW && cfg_req.addr != BTH_OFS_BASE_HIGH
    |=> cfg_rdata == 32'h00000000)
    else $error("unmapped offset not zero");
endmodule

/* File: verification/tb_bridge_type1_header_ids_bars.sv */
// Purpose: self-checking bench for the bridge identity, cache line, latency and BAR words
// Assumes: read data valid one cycle after the read request
// Notes: inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module tb_bridge_type1_header_ids_bars;
  import bth_pkg::*;
  logic clk, nrst, reverse_mode, pcix_mode, bus_64;
  bth_cfg_req_t cfg_req;
  bth_eep_t eep;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  logic [5:0] cache_line_dw;
  logic [7:0] prim_latency;
  logic [63:0] window_base;
  int failures, checks;
  bth_header_regs #(.SILICON_REV(8'hA5)) dut_u (.clk(clk), .nrst(nrst),
    .reverse_mode(reverse_mode), .pcix_mode(pcix_mode), .bus_64(bus_64), .cfg_req(cfg_req),
    .eep(eep), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cache_line_dw(cache_line_dw),
    .prim_latency(prim_latency), .window_base(window_base));
  // Free-running clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset held for 16 cycles, two cycles after release for the latency preset
  task automatic do_reset(logic rev, logic pcx);
    nrst <= 1'b0;
    reverse_mode <= rev;
    pcix_mode <= pcx;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic cfg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    cfg_req <= {1'b0, 1'b1, a, 4'hF, d};
    @(posedge clk);
    cfg_req <= '0;
  endtask
  task automatic cfg_rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    cfg_req <= {1'b1, 1'b0, a, 4'hF, 32'h00000000};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    chk("rvalid", cfg_rvalid, 1'b1);
    chk("rdata", cfg_rdata, exp);
  endtask
  task automatic eep_ld(bth_eep_t e);
    @(posedge clk);
    eep <= e;
    @(posedge clk);
    eep <= '0;
  endtask
  // Identity words after reset, write to the class word, EEPROM revision
  task automatic t_ident();
    do_reset(1'b0, 1'b0);
    cfg_rd(8'h08, 32'h060400A5);
    cfg_rd(8'h0C, 32'h00010000);
    cfg_wr(8'h08, 32'hFFFFFFFF);
    cfg_rd(8'h08, 32'h060400A5);
    eep_ld('{ld_rev: 1'b1, rev: 8'h3C, default: '0});
    cfg_rd(8'h08, 32'h0604003C);
    cfg_rd(8'h40, 32'h00000000);
  endtask
  // Cache line codes and zero meaning, forward latency stays zero
  task automatic t_cache();
    cfg_wr(8'h0C, 32'hFFFFFF20);
    cfg_rd(8'h0C, 32'h00010020);
    #1 chk("cl_dw", cache_line_dw, 6'h20);
    chk("lat_fwd", prim_latency, 8'h00);
    cfg_wr(8'h0C, 32'h00000000);
    @(posedge clk) bus_64 <= 1'b1;
    @(posedge clk) #1 chk("cl_dw64", cache_line_dw, 6'h02);
    @(posedge clk) bus_64 <= 1'b0;
    @(posedge clk) #1 chk("cl_dw32", cache_line_dw, 6'h01);
  endtask
  // Reverse mode latency reset values and write access
  task automatic t_latency();
    do_reset(1'b1, 1'b1);
    cfg_rd(8'h0C, 32'h00014000);
    cfg_wr(8'h0C, 32'h00005500);
    cfg_rd(8'h0C, 32'h00015500);
    #1 chk("lat_rev", prim_latency, 8'h55);
    do_reset(1'b1, 1'b0);
    cfg_rd(8'h0C, 32'h00010000);
  endtask
  // BAR pair in 32-bit then 64-bit map type
  task automatic t_bar();
    do_reset(1'b0, 1'b0);
    cfg_wr(8'h10, 32'hFFFFFFFF);
    cfg_rd(8'h10, 32'hFFFFE000);
    cfg_wr(8'h14, 32'hFFFFFFFF);
    cfg_rd(8'h14, 32'h00000000);
    #1 chk("win32", window_base, 64'h00000000FFFFE000);
    eep_ld('{ld_map: 1'b1, map: BTH_MAP_64, default: '0});
    cfg_rd(8'h10, 32'hFFFFE004);
    cfg_wr(8'h14, 32'h12345678);
    cfg_rd(8'h14, 32'h12345678);
    #1 chk("win64", window_base, 64'h12345678FFFFE000);
  endtask
  // Watchdog on the whole run
  initial begin
    #200us;
    failures++;
    report_and_stop();
  end
  initial begin
    failures = 0;
    checks = 0;
    nrst = 1'b0;
    reverse_mode = 1'b0;
    pcix_mode = 1'b0;
    bus_64 = 1'b0;
    cfg_req = '0;
    eep = '0;
    t_ident();
    t_cache();
    t_latency();
    t_bar();
    report_and_stop();
  end
endmodule
